//--- hw/adc_result_port.sv
// Channel-to-register map, offset DAC decode and serial result word port.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Offset code: sign plus magnitude, zero disconnects
// - Normal unscanned mode picks register by channel
// - Offset calibration converts zero pair, normal register
// - Gain calibration converts span pair, normal register
// - Scanning ignores selects; calibration pairs use three
// - Result is a read-only 24-bit word
// - Writing the result word changes nothing
// - After result write, discard eight bits, idle
// - Shift value, reserved, aux, tag, MSB first
// - Value is 18-bit offset binary
// - Out-of-range input saturates to min or max
// - Reserved bit after value is always zero
// - Aux bits captured at first falling edge
// - Tag codes: pseudo 0-3, pairs 4-6, cal 7
// - Register: gain, polarity, offset; resets zero
// - Polarity zero bipolar, one unipolar scale
module adc_result_port (
   input  wire  logic        clock,
   input  wire  logic        rst,
   input  wire  logic        ce,
   input  wire  logic        sclk_pin,
   input  wire  logic        sdin_pin,
   output var   logic        sdout,
   output var   logic        sdout_oe_n,
   input  wire  logic        aux_status_hi,
   input  wire  logic        aux_status_lo,
   input  wire  logic        cal_mode_sel_hi,
   input  wire  logic        cal_mode_sel_lo,
   input  wire  logic        full_pair_select,
   input  wire  logic        chan_sel_hi,
   input  wire  logic        chan_sel_lo,
   input  wire  logic        scan_enable,
   input  wire  logic [2:0]  scan_slot_tag,
   input  wire  logic        tf_load,
   input  wire  logic [1:0]  tf_load_sel,
   input  wire  logic [7:0]  tf_load_data,
   input  wire  logic        data_read_start,
   input  wire  logic        data_write_start,
   input  wire  logic        conv_valid,
   input  wire  logic [17:0] conv_value,
   input  wire  logic        conv_over,
   input  wire  logic        conv_under,
   output logic [1:0]        active_tf_sel,
   output logic [2:0]        pga_gain_code,
   output logic              unipolar,
   output logic              dac_connected,
   output logic              offset_sign_bit,
   output logic [2:0]        dac_magnitude,
   output logic [11:0]       dac_value_tenths,
   output logic              zero_cal_input,
   output logic              span_cal_input,
   output logic              port_idle
);

   // Pin synchronisers: sclk, sdin, aux high, aux low.
   logic [3:0]                 pin_raw;
   logic [3:0]                 meta_q;
   logic [3:0]                 sync_q;
   logic                       sclk_prev_q;
   logic [7:0]                 tf_q [adc_map_pkg::TF_COUNT];
   logic [23:0]                result_q;
   logic [23:0]                shift_q;
   logic [4:0]                 count_q;
   adc_map_pkg::port_state_t   state_q;

   assign pin_raw = {sclk_pin, sdin_pin, aux_status_hi, aux_status_lo};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge clock) begin
            if (rst) begin
               meta_q[gi] <= 1'b0;
               sync_q[gi] <= 1'b0;
            end else if (ce) begin
               meta_q[gi] <= pin_raw[gi];
               sync_q[gi] <= meta_q[gi];
            end
         end
      end
   endgenerate

   wire sclk_s   = sync_q[3];
   wire aux_hi_s = sync_q[1];
   wire aux_lo_s = sync_q[0];
   wire sclk_fall = sclk_prev_q & ~sclk_s;
   wire sclk_rise = ~sclk_prev_q & sclk_s;

   // Mode decode; the reserved calibration setting behaves as normal mode.
   wire off_cal  = cal_mode_sel_lo & ~cal_mode_sel_hi;
   wire gain_cal = cal_mode_sel_hi & ~cal_mode_sel_lo;
   wire cal_mode = off_cal | gain_cal;

   wire [2:0] normal_tag = full_pair_select ?
                           (adc_map_pkg::TAG_PAIR_BASE | {1'b0, chan_sel_hi, chan_sel_lo}) :
                           {1'b0, chan_sel_hi, chan_sel_lo};
   wire       unusable   = full_pair_select & chan_sel_hi & chan_sel_lo;
   wire [1:0] fixed_sel  = unusable ? adc_map_pkg::TF_SEL_ONE : adc_map_pkg::tag_to_tf(normal_tag);
   wire [1:0] scan_sel   = adc_map_pkg::tag_to_tf(scan_slot_tag);
   wire [1:0] sel_d      = scan_enable ? scan_sel : fixed_sel;
   wire [7:0] tf_sel     = tf_q[sel_d - 2'h1];

   wire [2:0] live_tag   = scan_enable ? scan_slot_tag :
                           (cal_mode ? adc_map_pkg::TAG_CAL : normal_tag);

   wire [2:0] mag_w      = tf_sel[adc_map_pkg::TF_MAG_MSB:adc_map_pkg::TF_MAG_LSB];
   wire       unip_w     = tf_sel[adc_map_pkg::TF_POL_BIT];
   wire       sign_w     = tf_sel[adc_map_pkg::TF_SIGN_BIT];
   wire [11:0] dac_abs   = unip_w ? adc_map_pkg::DAC_UNIPOLAR[mag_w] :
                                    adc_map_pkg::DAC_BIPOLAR[mag_w];
   wire [11:0] dac_w     = sign_w ? (12'h000 - dac_abs) : dac_abs;

   wire [17:0] value_w   = conv_over  ? adc_map_pkg::VALUE_MAX :
                           conv_under ? adc_map_pkg::VALUE_MIN : conv_value;

   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < adc_map_pkg::TF_COUNT; i++) begin
            tf_q[i] <= adc_map_pkg::TF_RESET;
         end
      end else if (ce && tf_load && tf_load_sel != 2'h0) begin
         tf_q[tf_load_sel - 2'h1] <= tf_load_data;
      end
   end

   // Decoded outputs are registered so the analog side sees no glitches.
   always_ff @(posedge clock) begin
      if (rst) begin
         active_tf_sel    <= adc_map_pkg::TF_SEL_ONE;
         pga_gain_code    <= 3'h0;
         unipolar         <= 1'b0;
         dac_connected    <= 1'b0;
         offset_sign_bit  <= 1'b0;
         dac_magnitude    <= 3'h0;
         dac_value_tenths <= 12'h000;
         zero_cal_input   <= 1'b0;
         span_cal_input   <= 1'b0;
      end else if (ce) begin
         active_tf_sel    <= sel_d;
         pga_gain_code    <= tf_sel[adc_map_pkg::TF_GAIN_MSB:adc_map_pkg::TF_GAIN_LSB];
         unipolar         <= unip_w;
         dac_connected    <= (mag_w != 3'h0);
         offset_sign_bit  <= sign_w;
         dac_magnitude    <= mag_w;
         dac_value_tenths <= dac_w;
         zero_cal_input   <= off_cal & ~scan_enable;
         span_cal_input   <= gain_cal & ~scan_enable;
      end
   end

   // result word, only the converter updates it
   always_ff @(posedge clock) begin
      if (rst) begin
         result_q <= adc_map_pkg::RESULT_RESET;
      end else if (ce && conv_valid) begin
         result_q <= {value_w, 1'b0, 2'b00, live_tag};
      end
   end

   // Serial port: shift on falling sclk, count host bits on rising sclk.
   always_ff @(posedge clock) begin
      if (rst) begin
         sclk_prev_q <= 1'b0;
         shift_q     <= adc_map_pkg::RESULT_RESET;
         count_q     <= 5'h00;
         state_q     <= adc_map_pkg::PORT_IDLE;
      end else if (ce) begin
         sclk_prev_q <= sclk_s;
         unique case (state_q)
            adc_map_pkg::PORT_IDLE: begin
               count_q <= 5'h00;
               if (data_read_start) begin
                  shift_q <= result_q;
                  state_q <= adc_map_pkg::PORT_READ;
               end else if (data_write_start) begin
                  state_q <= adc_map_pkg::PORT_DISCARD;
               end
            end
            adc_map_pkg::PORT_READ: begin
               if (sclk_fall) begin
                  count_q <= count_q + 5'h01;
                  if (count_q == 5'h00) begin
                     shift_q <= {shift_q[22:5], aux_hi_s, aux_lo_s, shift_q[2:0], 1'b0};
                  end else begin
                     shift_q <= {shift_q[22:0], 1'b0};
                  end
                  if (count_q == adc_map_pkg::READ_BITS - 5'h01) begin
                     state_q <= adc_map_pkg::PORT_IDLE;
                  end
               end
            end
            adc_map_pkg::PORT_DISCARD: begin
               if (sclk_rise) begin
                  count_q <= count_q + 5'h01;
                  if (count_q == adc_map_pkg::DISCARD_BITS - 5'h01) begin
                     state_q <= adc_map_pkg::PORT_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // The aux bits sit in the second and third bit after the value only once
   // the first falling edge has passed; before that the word holds zeros there.
   assign sdout      = shift_q[23];
   assign sdout_oe_n = (state_q != adc_map_pkg::PORT_READ);
   assign port_idle  = (state_q == adc_map_pkg::PORT_IDLE);

   property p_dac_off;
      @(posedge clock) disable iff (rst) ce && mag_w == 3'h0 |=> !dac_connected;
   endproperty
   a_dac_off: assert property (p_dac_off) else $error("DAC not disconnected at zero.");

   property p_dac_scale;
      @(posedge clock) disable iff (rst)
         ce && !unip_w && sign_w && mag_w == 3'h7 |=> dac_value_tenths == 12'hdb9;
   endproperty
   a_dac_scale: assert property (p_dac_scale) else $error("Bipolar full negative wrong.");

   property p_norm_pair;
      @(posedge clock) disable iff (rst)
         ce && !scan_enable && full_pair_select && chan_sel_hi && !chan_sel_lo
         |=> active_tf_sel == 2'h3;
   endproperty
   a_norm_pair: assert property (p_norm_pair) else $error("Pair five-six not register three.");

   property p_unusable;
      @(posedge clock) disable iff (rst) ce && !scan_enable && unusable |=> active_tf_sel == 2'h1;
   endproperty
   a_unusable: assert property (p_unusable) else $error("Unusable code not register one.");

   property p_offcal;
      @(posedge clock) disable iff (rst)
         ce && off_cal && !scan_enable && !full_pair_select && chan_sel_hi
         |=> zero_cal_input && active_tf_sel == 2'h2;
   endproperty
   a_offcal: assert property (p_offcal) else $error("Offset calibration mapping wrong.");

   property p_gaincal;
      @(posedge clock) disable iff (rst)
         ce && gain_cal && !scan_enable && full_pair_select && !chan_sel_hi && chan_sel_lo
         |=> span_cal_input && active_tf_sel == 2'h2;
   endproperty
   a_gaincal: assert property (p_gaincal) else $error("Gain calibration mapping wrong.");

   property p_scan_cal;
      @(posedge clock) disable iff (rst)
         ce && scan_enable && scan_slot_tag == 3'h7 |=> active_tf_sel == 2'h3 && !zero_cal_input;
   endproperty
   a_scan_cal: assert property (p_scan_cal) else $error("Scanned calibration not register three.");

   property p_write_keeps;
      @(posedge clock) disable iff (rst)
         state_q == adc_map_pkg::PORT_DISCARD && !conv_valid |=> $stable(result_q);
   endproperty
   a_write_keeps: assert property (p_write_keeps) else $error("Result changed by a write.");

   property p_discard;
      @(posedge clock) disable iff (rst)
         ce && state_q == adc_map_pkg::PORT_DISCARD && sclk_rise && count_q == 5'h07
         |=> port_idle;
   endproperty
   a_discard: assert property (p_discard) else $error("Port not idle after eight bits.");

   property p_reserved;
      @(posedge clock) disable iff (rst) result_q[5] == 1'b0 && !(port_idle && !sdout_oe_n);
   endproperty
   a_reserved: assert property (p_reserved) else $error("Reserved bit set or port misdriven.");

   property p_saturate;
      @(posedge clock) disable iff (rst)
         ce && conv_valid && conv_over |=> result_q[23:6] == 18'h3ffff;
   endproperty
   a_saturate: assert property (p_saturate) else $error("Overrange not saturated.");

   property p_cal_tag;
      @(posedge clock) disable iff (rst)
         ce && conv_valid && cal_mode && !scan_enable |=> result_q[2:0] == 3'h7;
   endproperty
   a_cal_tag: assert property (p_cal_tag) else $error("Calibration tag wrong.");

   c_read:    cover property (@(posedge clock) disable iff (rst)
                 state_q == adc_map_pkg::PORT_READ ##1 port_idle);
   c_discard: cover property (@(posedge clock) disable iff (rst)
                 state_q == adc_map_pkg::PORT_DISCARD ##1 port_idle);
   c_scan3:   cover property (@(posedge clock) disable iff (rst)
                 ce && scan_enable && scan_slot_tag == 3'h6);

endmodule : adc_result_port

`default_nettype wire

//--- include/adc_map_pkg.sv
// Shared constants and types for the converter channel map and result port.
package adc_map_pkg;

   // Transfer-function register layout: gain code, polarity, offset code.
   localparam int TF_WIDTH      = 8;
   localparam int TF_GAIN_MSB   = 7;
   localparam int TF_GAIN_LSB   = 5;
   localparam int TF_POL_BIT    = 4;
   localparam int TF_SIGN_BIT   = 3;
   localparam int TF_MAG_MSB    = 2;
   localparam int TF_MAG_LSB    = 0;
   localparam logic [7:0] TF_RESET = 8'h00;
   localparam int TF_COUNT      = 3;

   // Register numbers as seen on the select output.
   localparam logic [1:0] TF_SEL_ONE   = 2'h1;
   localparam logic [1:0] TF_SEL_TWO   = 2'h2;
   localparam logic [1:0] TF_SEL_THREE = 2'h3;

   // Result word layout, most significant bit shifted first.
   localparam int WORD_BITS     = 24;
   localparam int VALUE_BITS    = 18;
   localparam int VALUE_LSB     = 6;
   localparam int RESERVED_BIT  = 5;
   localparam int AUX_HI_BIT    = 4;
   localparam int AUX_LO_BIT    = 3;
   localparam logic [23:0] RESULT_RESET = 24'h000000;
   localparam logic [17:0] VALUE_MIN = 18'h00000;
   localparam logic [17:0] VALUE_MAX = 18'h3ffff;

   // Bits the host must shift in after a write aimed at the result word, and shift out on a read.
   localparam logic [4:0] DISCARD_BITS = 5'h08;
   localparam logic [4:0] READ_BITS    = 5'h18;

   // Source channel tags.
   localparam logic [2:0] TAG_PAIR_BASE = 3'h4;
   localparam logic [2:0] TAG_CAL       = 3'h7;

   // Offset DAC value in tenths of a percent of full scale, per magnitude.
   localparam logic [11:0] DAC_BIPOLAR [8] = '{12'h000, 12'h053, 12'h0a7, 12'h0fa,
                                              12'h14d, 12'h1a0, 12'h1f4, 12'h247};
   localparam logic [11:0] DAC_UNIPOLAR [8] = '{12'h000, 12'h0a7, 12'h14d, 12'h1f4,
                                               12'h29b, 12'h341, 12'h3e8, 12'h48f};

   typedef enum logic [1:0] {
      PORT_IDLE,
      PORT_READ,
      PORT_DISCARD
   } port_state_t;

   // Register governing a channel tag; the calibration tag maps to the third.
   function automatic logic [1:0] tag_to_tf(input logic [2:0] tag);
      logic [1:0] sel;
      sel = TF_SEL_ONE;
      unique case (tag)
         3'h0, 3'h1, 3'h4: sel = TF_SEL_ONE;
         3'h2, 3'h3, 3'h5: sel = TF_SEL_TWO;
         3'h6, 3'h7:       sel = TF_SEL_THREE;
      endcase
      return sel;
   endfunction : tag_to_tf

endpackage : adc_map_pkg

//--- bench/host_serial_model.sv
// Host-side serial model that clocks result words out and discard bits in.
`timescale 1ns/100ps
`default_nettype none
module host_serial_model (
   output var  logic sclk_pin,
   output var  logic sdin_pin,
   input  wire logic sdout,
   input  wire logic sdout_oe_n
);
   localparam time HALF = 24ns;
   initial begin
      sclk_pin = 1'b1;
      sdin_pin = 1'b0;
   end
   // The serial clock stands high between frames; bits are taken before each fall.
   task automatic read_word(output logic [23:0] word, output logic driven);
      driven = 1'b1;
      for (int i = 23; i >= 0; i--) begin
         #HALF;
         word[i] = sdout;
         driven = driven & ~sdout_oe_n;
         // Pins move by non-blocking assignment so a change on a clock edge is never raced.
         sclk_pin <= 1'b0;
         #HALF;
         sclk_pin <= 1'b1;
      end
   endtask : read_word
   task automatic write_bits(input int n);
      for (int i = 0; i < n; i++) begin
         sclk_pin <= 1'b0;
         sdin_pin <= ~sdin_pin;
         #HALF;
         sclk_pin <= 1'b1;
         #HALF;
      end
   endtask : write_bits
endmodule : host_serial_model
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench for the channel map, offset decode and result port.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   localparam logic [11:0] BIP [8] = '{12'h000, 12'h053, 12'h0a7, 12'h0fa,
                                       12'h14d, 12'h1a0, 12'h1f4, 12'h247};
   localparam logic [11:0] UNI [8] = '{12'h000, 12'h0a7, 12'h14d, 12'h1f4,
                                       12'h29b, 12'h341, 12'h3e8, 12'h48f};
   logic clock, rst, ce, sclk_pin, sdin_pin, sdout, sdout_oe_n, aux_status_hi, aux_status_lo;
   logic cal_mode_sel_hi, cal_mode_sel_lo, full_pair_select, chan_sel_hi, chan_sel_lo;
   logic scan_enable, tf_load, data_read_start, data_write_start, conv_valid, conv_over;
   logic conv_under, unipolar, dac_connected, offset_sign_bit, zero_cal_input;
   logic span_cal_input, port_idle;
   logic [2:0]  scan_slot_tag, pga_gain_code, dac_magnitude;
   logic [1:0]  tf_load_sel, active_tf_sel;
   logic [7:0]  tf_load_data;
   logic [17:0] conv_value;
   logic [11:0] dac_value_tenths;
   logic [7:0]  tfv [1:3];
   int          err_total;
   int          check_count;

   adc_result_port u_adc_result_port (.*);
   host_serial_model u_host_serial_model (.*);

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic tally_and_finish;
      if (err_total == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   function automatic logic [11:0] exp_tenths(input logic [4:0] pc);
      logic [11:0] v;
      v = pc[4] ? UNI[pc[2:0]] : BIP[pc[2:0]];
      return pc[3] ? -v : v;
   endfunction : exp_tenths

   task automatic setup(input logic [1:0] m, input logic d, input logic [1:0] s,
                        input logic sc, input logic [2:0] tg, input logic [1:0] ax);
      @(posedge clock);
      {cal_mode_sel_hi, cal_mode_sel_lo} <= m;
      {full_pair_select, chan_sel_hi, chan_sel_lo} <= {d, s};
      {scan_enable, scan_slot_tag, aux_status_hi, aux_status_lo} <= {sc, tg, ax};
      repeat (3) @(posedge clock);
      #1;
   endtask : setup

   task automatic tf_write(input logic [1:0] r, input logic [7:0] v);
      @(posedge clock);
      {tf_load, tf_load_sel, tf_load_data} <= {1'b1, r, v};
      @(posedge clock);
      tf_load <= 1'b0;
      tfv[r] = v;
   endtask : tf_write

   task automatic chk_regs(input logic [1:0] r);
      chk("register select", 24'(r), 24'(active_tf_sel));
      chk("register fields", 24'(tfv[r]), 24'({pga_gain_code, unipolar, offset_sign_bit,
                                                 dac_magnitude}));
      chk("dac connected", 24'(|tfv[r][2:0]), 24'(dac_connected));
      chk("dac value", 24'(exp_tenths(tfv[r][4:0])), 24'(dac_value_tenths));
   endtask : chk_regs

   task automatic wait_idle;
      for (int n = 0; n < 60 && port_idle !== 1'b1; n++) begin
         @(posedge clock);
         #1;
      end
      if (port_idle !== 1'b1) begin
         chk("port back to idle", 24'h1, 24'(port_idle));
         tally_and_finish();
      end
   endtask : wait_idle

   task automatic store(input logic [17:0] v, input logic ov, input logic un);
      @(posedge clock);
      {conv_valid, conv_value, conv_over, conv_under} <= {1'b1, v, ov, un};
      @(posedge clock);
      conv_valid <= 1'b0;
   endtask : store

   task automatic read_chk(input logic [23:0] exp);
      logic [23:0] w;
      logic        drv;
      @(posedge clock);
      data_read_start <= 1'b1;
      @(posedge clock);
      data_read_start <= 1'b0;
      fork
         u_host_serial_model.read_word(w, drv);
         begin
            // Aux pins move after the first fall; the word must keep the earlier level.
            #120;
            @(posedge clock);
            {aux_status_hi, aux_status_lo} <= ~{aux_status_hi, aux_status_lo};
         end
      join
      chk("result word", exp, w);
      chk("output driven", 24'h1, 24'(drv));
      wait_idle();
   endtask : read_chk

   task automatic t_reset;
      chk("idle after reset", 24'h1, 24'({port_idle, sdout_oe_n} == 2'b11));
      chk_regs(2'h1);
   endtask : t_reset

   task automatic t_map;
      logic [1:0] e;
      tf_write(2'h1, 8'h21);
      tf_write(2'h2, 8'h59);
      tf_write(2'h3, 8'h67);
      for (int m = 0; m < 3; m++) for (int c = 0; c < 8; c++) begin
         // forbidden pair select with both selects, tried once in normal mode
         if (c == 7 && m != 0) continue;
         e = c[2] ? ((c[1:0] == 2'h3) ? 2'h1 : c[1:0] + 2'h1) : (c[1] ? 2'h2 : 2'h1);
         setup(2'(m), c[2], c[1:0], 1'b0, 3'h0, 2'h0);
         chk_regs(e);
         chk("zero cal", 24'(m == 1), 24'(zero_cal_input));
         chk("span cal", 24'(m == 2), 24'(span_cal_input));
      end
   endtask : t_map

   task automatic t_scan;
      for (int t = 0; t < 8; t++) begin
         setup(2'h1, 1'b0, 2'h3, 1'b1, 3'(t), 2'h0);
         chk_regs((t >= 6) ? 2'h3 : (t == 2 || t == 3 || t == 5) ? 2'h2 : 2'h1);
      end
   endtask : t_scan

   task automatic t_dac;
      setup(2'h0, 1'b0, 2'h0, 1'b0, 3'h0, 2'h0);
      for (int c = 0; c < 32; c++) begin
         tf_write(2'h1, {3'h5, 5'(c)});
         repeat (2) @(posedge clock);
         #1;
         chk_regs(2'h1);
      end
   endtask : t_dac

   task automatic t_freeze;
      logic [7:0] keep;
      keep = tfv[1];
      @(posedge clock);
      ce <= 1'b0;
      // A load offered to register one while the enable is low must leave it as it was.
      tf_write(2'h1, ~keep);
      repeat (3) @(posedge clock);
      #1;
      tfv[1] = keep;
      chk_regs(2'h1);
      @(posedge clock);
      ce <= 1'b1;
   endtask : t_freeze

   task automatic t_result;
      setup(2'h0, 1'b1, 2'h2, 1'b0, 3'h0, 2'h2);
      store(18'h2a5c3, 1'b0, 1'b0);
      read_chk({18'h2a5c3, 1'b0, 2'h2, 3'h6});
      setup(2'h0, 1'b0, 2'h3, 1'b0, 3'h0, 2'h1);
      store(18'h00005, 1'b1, 1'b0);
      read_chk({18'h3ffff, 1'b0, 2'h1, 3'h3});
      setup(2'h2, 1'b0, 2'h1, 1'b0, 3'h0, 2'h3);
      store(18'h12345, 1'b0, 1'b1);
      read_chk({18'h00000, 1'b0, 2'h3, 3'h7});
      setup(2'h0, 1'b1, 2'h0, 1'b1, 3'h5, 2'h0);
      store(18'h00001, 1'b0, 1'b0);
      read_chk({18'h00001, 1'b0, 2'h0, 3'h5});
   endtask : t_result

   task automatic t_write;
      setup(2'h0, 1'b1, 2'h0, 1'b1, 3'h5, 2'h1);
      @(posedge clock);
      data_write_start <= 1'b1;
      @(posedge clock);
      data_write_start <= 1'b0;
      @(posedge clock);
      #1;
      chk("busy after write", 24'h0, 24'(port_idle));
      u_host_serial_model.write_bits(7);
      repeat (12) @(posedge clock);
      #1;
      chk("busy after seven bits", 24'h0, 24'({port_idle, ~sdout_oe_n}));
      u_host_serial_model.write_bits(1);
      wait_idle();
      read_chk({18'h00001, 1'b0, 2'h1, 3'h5});
   endtask : t_write

   initial begin
      {rst, ce} = 2'b11;
      {aux_status_hi, aux_status_lo, cal_mode_sel_hi, cal_mode_sel_lo} = 4'h0;
      {full_pair_select, chan_sel_hi, chan_sel_lo, scan_enable, scan_slot_tag} = 6'h00;
      {tf_load, tf_load_sel, tf_load_data, data_read_start, data_write_start} = 13'h0000;
      {conv_valid, conv_value, conv_over, conv_under} = 21'h000000;
      tfv = '{8'h00, 8'h00, 8'h00};
      err_total = 0;
      check_count = 0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      t_reset();
      t_map();
      t_scan();
      t_dac();
      t_freeze();
      t_result();
      t_write();
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
